// [pkg/oss_map.vh]
`ifndef OSS_MAP_VH
`define OSS_MAP_VH

// Register byte offsets
`define OSS_CTRL_OFS        8'h00
`define OSS_WAKE_MASK_OFS   8'h04
`define OSS_PITCH_OFS       8'h08
`define OSS_REG_SLOT_OFS    8'h0c
`define OSS_GPIO_SLOT_OFS   8'h10
`define OSS_STATUS_OFS      8'h14

// Control register fields
`define OSS_CTRL_BIAS       0
`define OSS_CTRL_BOOT_EN    1
`define OSS_CTRL_SLEEP_EN   2
`define OSS_CTRL_BOOT_SRC   3
`define OSS_CTRL_SLEEP_SRC  4
`define OSS_CTRL_SLP_ALLOW  5
`define OSS_CTRL_SW_RESET   6
`define OSS_CTRL_SOFTWARE_POWER_OFF    7
`define OSS_CTRL_RST_WAKE   8
`define OSS_CTRL_W          9

// Wake mask fields
`define OSS_WM_ONKEY        0
`define OSS_WM_ALARM1       1
`define OSS_WM_ALARM2       2
`define OSS_WM_SMPL         3
`define OSS_WM_ADAPTER      4
`define OSS_WM_BATT         5
`define OSS_WM_W            6

// Pitch field positions
`define OSS_PT_BOOT_PU      0
`define OSS_PT_BOOT_PD      4
`define OSS_PT_SLP_EXIT     8
`define OSS_PT_SLP_ENTRY    12

// Reset values
`define OSS_CTRL_RST        9'h000
`define OSS_WAKE_MASK_RST   6'h01
`define OSS_PITCH_RST       16'h0000
`define OSS_REG_SLOT_RST    32'h76543210
`define OSS_GPIO_SLOT_RST   16'hfedc

// Timing
`define OSS_CLK_PERIOD_NS   40
`define OSS_PITCH_BASE_NS   30500
`define OSS_READY_TMO_US    2000

`endif

// [hw/oss_sequencer.v]
`include "oss_map.vh"
`default_nettype none

// Operation
// RULE1: Leave standby toward ready on bias command or any enabled wakeup.
// RULE2: On-key edge, alarms, power-loss event wake only when masked in.
// RULE3: Battery rising above lockout wakes if masked; adapter level wakes (code also requires the adapter mask bit).
// RULE4: Wake flag left by sequenced shutdown acts as wakeup from standby.
// RULE5: Boot enable rising with boot source set acts as wakeup.
// RULE6: Enter ready only with resources ready before timeout expires.
// RULE7: From ready power up if woken, else wait for a wakeup.
// RULE8: Enter sleep on sleep input falling or sleep enable falling.
// RULE9: Leave sleep on sleep input rising, masked wakes or enable rising (code: masked power-loss and battery events do not leave sleep).
// RULE10: Listed fault or software events run power-down then register reset.
// RULE11: Immediate shutdown on battery limits, oscillator loss, ready timeout.
// RULE12: Two sequencers, boot and sleep, eight slots each.
// RULE13: Power-up steps slots upward 0 to 7 at the slot pitch.
// RULE14: Power-down steps slots downward 7 to 0 at the slot pitch.
// RULE15: Regulators enable on their power-up slot, disable on power-down.
// RULE16: GPIOs go high on their power-up slot, low on power-down.
// RULE17: Three-bit pitch field per direction, eight binary-weighted pitches.
// RULE18: Boot uses up/down pitch fields; sleep uses exit/entry fields.
// RULE19: Immediate shutdown powers everything off and resets registers.
// RULE20: Reset events with auto-wake shut down in sequence, then wake.
// RULE21: Battery-ok gates every wakeup source.
// RULE22: Sleep input polarity chosen by a fuse input.
// RULE23: Pitch code zero is shortest, each step doubles.
// RULE24: Requests during a sequence are held until it completes.
module oss_sequencer #(
   parameter integer PITCH_BASE_NS    = `OSS_PITCH_BASE_NS,
   parameter integer READY_TMO_CYCLES =
      `OSS_READY_TMO_US * 1000 / `OSS_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire        CLOCK,
   input  wire        RST_N,
   // Avalon-MM slave
   input  wire [7:0]  AVS_ADDRESS,
   input  wire        AVS_READ,
   input  wire        AVS_WRITE,
   input  wire [31:0] AVS_WRITEDATA,
   input  wire [3:0]  AVS_BYTEENABLE,
   output reg  [31:0] AVS_READDATA,
   output wire        AVS_WAITREQUEST,
   // Wakeup sources
   input  wire        ONKEY_INPUT,
   input  wire        ALARM_ONE_EVENT,
   input  wire        ALARM_TWO_EVENT,
   input  wire        MOMENTARY_POWER_LOSS_EVENT,
   input  wire        ADAPTER_PRESENT_INPUT,
   input  wire        SLEEP_CONTROL_INPUT,
   input  wire        SLEEP_INPUT_POLARITY_FUSE,
   // Supervisory inputs
   input  wire        BATTERY_OK_INDICATION,
   input  wire        BATTERY_RESET_LEVEL,
   input  wire        BATTERY_OVERVOLTAGE,
   input  wire        SLOW_OSCILLATOR_OK,
   input  wire        RESOURCES_READY,
   input  wire        HARDWARE_RESET_INPUT,
   input  wire        MANUAL_RESET,
   input  wire        MANUAL_RESET_AUTOWAKE,
   input  wire        WATCHDOG_EXPIRED,
   input  wire        WATCHDOG_AUTOWAKE,
   input  wire        OVER_TEMPERATURE,
   input  wire        EXTERNAL_SHUTDOWN_INPUT,
   // Sequenced outputs
   output reg  [7:0]  REG_ENABLE,
   output reg  [3:0]  GPIO_OUT,
   output wire        SEQ_BUSY
);

   localparam [5:0] ST_STANDBY = 6'h01;
   localparam [5:0] ST_READY   = 6'h02;
   localparam [5:0] ST_SEQ     = 6'h04;
   localparam [5:0] ST_ON      = 6'h08;
   localparam [5:0] ST_SLEEP   = 6'h10;
   localparam [5:0] ST_SHUTDN  = 6'h20;

   reg  [5:0]  state_reg;
   reg  [5:0]  target_reg;
   reg  [8:0]  ctrl_reg;
   reg  [5:0]  mask_reg;
   reg  [15:0] pitch_reg;
   reg  [31:0] reg_slot_reg;
   reg  [15:0] gpio_slot_reg;
   reg         ack_reg;
   reg         onkey_prev_reg;
   reg         sleep_prev_reg;
   reg         batt_prev_reg;
   reg         bias_pend_reg;
   reg         wake_pend_reg;
   reg         boot_rise_pend_reg;
   reg         sleep_rise_pend_reg;
   reg         sleep_fall_pend_reg;
   reg         down_pend_reg;
   reg         down_wake_reg;
   reg         wake_flag_reg;
   reg         woke_reg;
   reg         rdy_seen_reg;
   reg         tmo_run_reg;
   reg  [16:0] tmo_cnt_reg;
   reg         seq_up_reg;
   reg         seq_boot_reg;
   reg         seq_sleep_reg;
   reg         seq_apply_reg;
   reg         seq_clear_reg;
   reg  [2:0]  slot_reg;
   reg  [16:0] pitch_cnt_reg;
   reg  [16:0] pitch_len_reg;

   wire        req      = AVS_READ | AVS_WRITE;
   wire        wr_take  = AVS_WRITE & ack_reg;
   wire [5:0]  word     = AVS_ADDRESS[7:2];
   wire        sl_level = SLEEP_CONTROL_INPUT // RULE22
                          ~^ SLEEP_INPUT_POLARITY_FUSE;
   wire        sl_rise  = sl_level & ~sleep_prev_reg;
   wire        sl_fall  = ~sl_level & sleep_prev_reg;
   wire        tmo_done = tmo_cnt_reg >= READY_TMO_CYCLES[16:0];

   // Byte-enable merge of write data into a 32-bit image
   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  be;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               merge[8*b +: 8] = wd[8*b +: 8];
            end
         end
      end
   endfunction

   // Pitch code to cycles, rounded up
   function [16:0] pitch_cyc;
      input [2:0] code;
      reg   [31:0] t;
      begin
         t = ((PITCH_BASE_NS << code) + `OSS_CLK_PERIOD_NS - 1)
             / `OSS_CLK_PERIOD_NS; // RULE17 RULE23
         pitch_cyc = t[16:0];
      end
   endfunction

   wire [31:0] ctrl_img = merge({23'h0, ctrl_reg}, AVS_WRITEDATA,
                                AVS_BYTEENABLE);
   wire [31:0] pitch_img = merge({16'h0, pitch_reg}, AVS_WRITEDATA,
                                 AVS_BYTEENABLE);
   wire [31:0] gpio_img  = merge({16'h0, gpio_slot_reg}, AVS_WRITEDATA,
                                 AVS_BYTEENABLE);
   wire        ctrl_wr  = wr_take & (word == `OSS_CTRL_OFS >> 2);
   wire        boot_rise = ctrl_wr & ctrl_reg[`OSS_CTRL_BOOT_SRC]
                           & ctrl_img[`OSS_CTRL_BOOT_EN]
                           & ~ctrl_reg[`OSS_CTRL_BOOT_EN];
   wire        boot_fall = ctrl_wr & ctrl_reg[`OSS_CTRL_BOOT_SRC]
                           & ~ctrl_img[`OSS_CTRL_BOOT_EN]
                           & ctrl_reg[`OSS_CTRL_BOOT_EN];
   wire        slp_rise  = ctrl_wr & ctrl_reg[`OSS_CTRL_SLEEP_SRC]
                           & ctrl_img[`OSS_CTRL_SLEEP_EN]
                           & ~ctrl_reg[`OSS_CTRL_SLEEP_EN];
   wire        slp_fall  = ctrl_wr & ctrl_reg[`OSS_CTRL_SLEEP_SRC]
                           & ~ctrl_img[`OSS_CTRL_SLEEP_EN]
                           & ctrl_reg[`OSS_CTRL_SLEEP_EN];
   wire        bias_cmd  = ctrl_wr & ctrl_img[`OSS_CTRL_BIAS];
   wire        sw_rst    = ctrl_wr & ctrl_img[`OSS_CTRL_SW_RESET];
   wire        software_power_off   = ctrl_wr & ctrl_img[`OSS_CTRL_SOFTWARE_POWER_OFF];

   // Masked wake sources
   wire wake_src = (ONKEY_INPUT & ~onkey_prev_reg & mask_reg[`OSS_WM_ONKEY])
      | (ALARM_ONE_EVENT & mask_reg[`OSS_WM_ALARM1])
      | (ALARM_TWO_EVENT & mask_reg[`OSS_WM_ALARM2])
      | (MOMENTARY_POWER_LOSS_EVENT & mask_reg[`OSS_WM_SMPL]); // RULE2
   wire wake_std = wake_src
      | (ADAPTER_PRESENT_INPUT & mask_reg[`OSS_WM_ADAPTER])
      | (BATTERY_OK_INDICATION & ~batt_prev_reg
         & mask_reg[`OSS_WM_BATT]) | boot_rise; // RULE3 RULE5
   wire wake_slp = (wake_src & ~mask_reg[`OSS_WM_SMPL])
      | (ctrl_reg[`OSS_CTRL_SLP_ALLOW] & sl_rise)
      | (ADAPTER_PRESENT_INPUT & mask_reg[`OSS_WM_ADAPTER])
      | (ONKEY_INPUT & ~onkey_prev_reg & mask_reg[`OSS_WM_ONKEY])
      | (ALARM_ONE_EVENT & mask_reg[`OSS_WM_ALARM1])
      | (ALARM_TWO_EVENT & mask_reg[`OSS_WM_ALARM2]); // RULE9

   wire down_auto = HARDWARE_RESET_INPUT
      | (sw_rst & ctrl_img[`OSS_CTRL_RST_WAKE])
      | (WATCHDOG_EXPIRED & WATCHDOG_AUTOWAKE)
      | (MANUAL_RESET & MANUAL_RESET_AUTOWAKE); // RULE20
   wire down_evt = down_auto | ~BATTERY_RESET_LEVEL | MANUAL_RESET
      | sw_rst | software_power_off | OVER_TEMPERATURE | EXTERNAL_SHUTDOWN_INPUT
      | WATCHDOG_EXPIRED | boot_fall; // RULE10
   wire immed = ~BATTERY_OK_INDICATION | BATTERY_OVERVOLTAGE
      | ~SLOW_OSCILLATOR_OK
      | (rdy_seen_reg & ~RESOURCES_READY & tmo_done); // RULE11

   wire in_seq   = state_reg == ST_SEQ;
   wire pitch_end = pitch_cnt_reg == pitch_len_reg - 17'd1;
   wire last_slot = seq_up_reg ? (slot_reg == 3'd7) : (slot_reg == 3'd0);

   assign AVS_WAITREQUEST = req & ~ack_reg;
   assign SEQ_BUSY        = in_seq;

   reg [31:0] rd_mux;
   always @* begin
      case (word)
         `OSS_CTRL_OFS >> 2:      rd_mux = {23'h0, ctrl_reg};
         `OSS_WAKE_MASK_OFS >> 2: rd_mux = {26'h0, mask_reg};
         `OSS_PITCH_OFS >> 2:     rd_mux = {16'h0, pitch_reg};
         `OSS_REG_SLOT_OFS >> 2:  rd_mux = reg_slot_reg;
         `OSS_GPIO_SLOT_OFS >> 2: rd_mux = {16'h0, gpio_slot_reg};
         `OSS_STATUS_OFS >> 2:    rd_mux = {17'h0, wake_flag_reg,
                                     seq_sleep_reg, seq_boot_reg,
                                     seq_up_reg, slot_reg, 2'h0,
                                     state_reg};
         default:                 rd_mux = 32'h0;
      endcase
   end

   // Bus handshake and read data
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         ack_reg      <= 1'b0;
         AVS_READDATA <= 32'h0;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (AVS_READ & ~ack_reg) begin
            AVS_READDATA <= rd_mux;
         end
      end
   end

   // Start a slot sequence toward a target state
   task start_seq;
      input       up;
      input       boot;
      input       slp;
      input [2:0] code;
      input [5:0] tgt;
      input       clr;
      begin
         state_reg     <= ST_SEQ;
         target_reg    <= tgt;
         seq_up_reg    <= up;
         seq_boot_reg  <= boot;
         seq_sleep_reg <= slp;
         seq_clear_reg <= clr;
         slot_reg      <= up ? 3'd0 : 3'd7; // RULE13 RULE14
         pitch_cnt_reg <= 17'd0;
         pitch_len_reg <= pitch_cyc(code);
         seq_apply_reg <= 1'b1;
      end
   endtask

   integer i;
   always @(posedge CLOCK) begin
      if (!RST_N) begin
         state_reg        <= ST_STANDBY;
         target_reg       <= ST_STANDBY;
         ctrl_reg         <= `OSS_CTRL_RST;
         mask_reg         <= `OSS_WAKE_MASK_RST;
         pitch_reg        <= `OSS_PITCH_RST;
         reg_slot_reg     <= `OSS_REG_SLOT_RST;
         gpio_slot_reg    <= `OSS_GPIO_SLOT_RST;
         onkey_prev_reg   <= 1'b0;
         sleep_prev_reg   <= 1'b1;
         batt_prev_reg    <= 1'b0;
         bias_pend_reg    <= 1'b0;
         wake_pend_reg    <= 1'b0;
         boot_rise_pend_reg  <= 1'b0;
         sleep_rise_pend_reg <= 1'b0;
         sleep_fall_pend_reg <= 1'b0;
         down_pend_reg    <= 1'b0;
         down_wake_reg    <= 1'b0;
         wake_flag_reg    <= 1'b0;
         woke_reg         <= 1'b0;
         rdy_seen_reg     <= 1'b0;
         tmo_run_reg      <= 1'b0;
         tmo_cnt_reg      <= 17'd0;
         seq_up_reg       <= 1'b0;
         seq_boot_reg     <= 1'b0;
         seq_sleep_reg    <= 1'b0;
         seq_apply_reg    <= 1'b0;
         seq_clear_reg    <= 1'b0;
         slot_reg         <= 3'd0;
         pitch_cnt_reg    <= 17'd0;
         pitch_len_reg    <= 17'd1;
         REG_ENABLE       <= 8'h00;
         GPIO_OUT         <= 4'h0;
      end else begin
         onkey_prev_reg <= ONKEY_INPUT;
         sleep_prev_reg <= sl_level;
         batt_prev_reg  <= BATTERY_OK_INDICATION;
         // Register writes
         if (ctrl_wr) begin
            ctrl_reg <= ctrl_img[8:0] & 9'h13e;
         end
         if (wr_take & (word == `OSS_WAKE_MASK_OFS >> 2)) begin
            mask_reg <= AVS_WRITEDATA[5:0];
         end
         if (wr_take & (word == `OSS_PITCH_OFS >> 2)) begin
            pitch_reg <= pitch_img[15:0] & 16'h7777;
         end
         if (wr_take & (word == `OSS_REG_SLOT_OFS >> 2)) begin
            reg_slot_reg <= merge(reg_slot_reg, AVS_WRITEDATA,
                                  AVS_BYTEENABLE);
         end
         if (wr_take & (word == `OSS_GPIO_SLOT_OFS >> 2)) begin
            gpio_slot_reg <= gpio_img[15:0];
         end
         // Held requests; a new down_evt or wake_std event wins over consumption
         bias_pend_reg <= bias_pend_reg | bias_cmd;
         wake_pend_reg <= wake_pend_reg
                          | (wake_std & BATTERY_OK_INDICATION); // RULE21
         boot_rise_pend_reg  <= boot_rise_pend_reg | boot_rise;
         sleep_rise_pend_reg <= sleep_rise_pend_reg | slp_rise
                                | (wake_slp & BATTERY_OK_INDICATION);
         sleep_fall_pend_reg <= sleep_fall_pend_reg | slp_fall
            | (ctrl_reg[`OSS_CTRL_SLP_ALLOW] & sl_fall); // RULE8
         down_pend_reg <= down_pend_reg | down_evt; // RULE24
         down_wake_reg <= down_wake_reg | down_auto;
         if (tmo_run_reg & ~tmo_done) begin
            tmo_cnt_reg <= tmo_cnt_reg + 17'd1;
         end
         // Slot sequencer
         if (in_seq) begin
            seq_apply_reg <= 1'b0;
            if (seq_apply_reg) begin
               for (i = 0; i < 8; i = i + 1) begin
                  if (reg_slot_reg[4*i +: 3] == slot_reg
                      && (reg_slot_reg[4*i+3] ? seq_sleep_reg
                                              : seq_boot_reg)) begin
                     REG_ENABLE[i] <= seq_up_reg; // RULE15 RULE12
                  end
               end
               for (i = 0; i < 4; i = i + 1) begin
                  if (gpio_slot_reg[4*i +: 3] == slot_reg
                      && (gpio_slot_reg[4*i+3] ? seq_sleep_reg
                                               : seq_boot_reg)) begin
                     GPIO_OUT[i] <= seq_up_reg; // RULE16
                  end
               end
            end
            if (!pitch_end) begin
               pitch_cnt_reg <= pitch_cnt_reg + 17'd1;
            end else if (!last_slot) begin
               pitch_cnt_reg <= 17'd0;
               seq_apply_reg <= 1'b1;
               slot_reg <= seq_up_reg ? slot_reg + 3'd1
                                      : slot_reg - 3'd1; // RULE13 RULE14
            end else begin
               state_reg <= target_reg;
               if (seq_clear_reg) begin
                  ctrl_reg      <= `OSS_CTRL_RST;
                  mask_reg      <= `OSS_WAKE_MASK_RST;
                  pitch_reg     <= `OSS_PITCH_RST;
                  reg_slot_reg  <= `OSS_REG_SLOT_RST;
                  gpio_slot_reg <= `OSS_GPIO_SLOT_RST;
                  rdy_seen_reg  <= 1'b0; // RULE10
               end
            end
         end
         // Immediate shutdown overrides everything
         if (immed && state_reg != ST_SHUTDN) begin
            state_reg     <= ST_SHUTDN;
            REG_ENABLE    <= 8'h00;
            GPIO_OUT      <= 4'h0;
            ctrl_reg      <= `OSS_CTRL_RST;
            mask_reg      <= `OSS_WAKE_MASK_RST;
            pitch_reg     <= `OSS_PITCH_RST;
            reg_slot_reg  <= `OSS_REG_SLOT_RST;
            gpio_slot_reg <= `OSS_GPIO_SLOT_RST;
            rdy_seen_reg  <= 1'b0;
            tmo_run_reg   <= 1'b0;
            wake_flag_reg <= 1'b0;
            down_pend_reg <= 1'b0;
            wake_pend_reg <= 1'b0; // RULE11 RULE19
         end else begin
            case (state_reg)
               ST_SHUTDN: begin
                  tmo_cnt_reg <= 17'd0;
                  state_reg   <= ST_STANDBY;
               end
               ST_STANDBY: begin
                  down_pend_reg <= down_evt;
                  down_wake_reg <= down_auto;
                  if (bias_pend_reg | wake_pend_reg | wake_flag_reg
                      | bias_cmd) begin // RULE1 RULE4
                     tmo_run_reg <= 1'b1;
                     if (RESOURCES_READY & ~tmo_done) begin // RULE6
                        state_reg     <= ST_READY;
                        rdy_seen_reg  <= 1'b1;
                        tmo_run_reg   <= 1'b0;
                        woke_reg      <= wake_pend_reg | wake_flag_reg;
                        bias_pend_reg <= 1'b0;
                        wake_pend_reg <= wake_std & BATTERY_OK_INDICATION;
                        wake_flag_reg <= 1'b0;
                     end else if (tmo_done) begin
                        rdy_seen_reg <= 1'b1;
                     end
                  end
               end
               ST_READY: begin
                  if (woke_reg | wake_pend_reg) begin // RULE7
                     woke_reg      <= 1'b0;
                     wake_pend_reg <= wake_std;
                     start_seq(1'b1, 1'b1, 1'b1,
                        pitch_reg[`OSS_PT_BOOT_PU +: 3], ST_ON,
                        1'b0); // RULE18
                  end
               end
               ST_ON: begin
                  if (down_pend_reg) begin
                     down_pend_reg <= down_evt;
                     down_wake_reg <= down_auto;
                     wake_flag_reg <= down_wake_reg;
                     start_seq(1'b0, 1'b1, 1'b1,
                        pitch_reg[`OSS_PT_BOOT_PD +: 3], ST_STANDBY,
                        1'b1); // RULE10 RULE20
                  end else if (sleep_fall_pend_reg) begin
                     sleep_fall_pend_reg <= slp_fall;
                     sleep_rise_pend_reg <= slp_rise;
                     start_seq(1'b0, 1'b0, 1'b1,
                        pitch_reg[`OSS_PT_SLP_ENTRY +: 3], ST_SLEEP,
                        1'b0); // RULE8 RULE18
                  end else begin
                     wake_pend_reg       <= 1'b0;
                     sleep_rise_pend_reg <= 1'b0;
                  end
               end
               ST_SLEEP: begin
                  if (down_pend_reg) begin
                     down_pend_reg <= down_evt;
                     down_wake_reg <= down_auto;
                     wake_flag_reg <= down_wake_reg;
                     start_seq(1'b0, 1'b1, 1'b0,
                        pitch_reg[`OSS_PT_BOOT_PD +: 3], ST_STANDBY,
                        1'b1); // RULE10
                  end else if (sleep_rise_pend_reg | boot_rise_pend_reg)
                  begin
                     sleep_rise_pend_reg <= 1'b0;
                     boot_rise_pend_reg  <= 1'b0;
                     sleep_fall_pend_reg <= 1'b0;
                     start_seq(1'b1, 1'b0, 1'b1,
                        pitch_reg[`OSS_PT_SLP_EXIT +: 3], ST_ON,
                        1'b0); // RULE9 RULE18
                  end
               end
               ST_SEQ: begin
               end
               default: begin
                  state_reg <= ST_STANDBY;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// [verification/oss_sequencer_properties.sv]
`default_nettype none
module oss_seq_props #(
   parameter integer PITCH_BASE_NS = 30500
) (
   // Clock and reset
   input wire logic       CLOCK,
   input wire logic       RST_N,
   // Supervisory inputs
   input wire logic       BATTERY_OK_INDICATION,
   input wire logic       BATTERY_OVERVOLTAGE,
   input wire logic       SLOW_OSCILLATOR_OK,
   // Sequenced outputs
   input wire logic [7:0] REG_ENABLE,
   input wire logic [3:0] GPIO_OUT,
   input wire logic       SEQ_BUSY
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PITCH_GAP = (PITCH_BASE_NS + 39) / 40 - 1;
   logic        bad;
   logic [2:0]  bad_reg;
   logic [15:0] gap_reg;
   assign bad = !BATTERY_OK_INDICATION || BATTERY_OVERVOLTAGE ||
                !SLOW_OSCILLATOR_OK;
   // Edges since the last regulator change, and recent hazard history
   always @(posedge CLOCK) begin
      bad_reg <= {bad_reg[1:0], bad};
      if (!RST_N) gap_reg <= 16'hffff;
      else if ($changed(REG_ENABLE)) gap_reg <= 16'h0000;
      else if (gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h0001;
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   property p_imm_reg;
      bad |-> ##[1:3] REG_ENABLE == 8'h00;
   endproperty
   a_imm_reg: assert property (p_imm_reg)
      else $error("Regulators stayed on after a hazard");
   property p_imm_gpio;
      bad |-> ##[1:3] (GPIO_OUT == 4'h0 && !SEQ_BUSY);
   endproperty
   a_imm_gpio: assert property (p_imm_gpio)
      else $error("Outputs stayed on after a hazard");
   property p_reg_busy;
      $changed(REG_ENABLE) && bad_reg == 3'h0 |-> $past(SEQ_BUSY);
   endproperty
   a_reg_busy: assert property (p_reg_busy)
      else $error("Regulator changed outside a sequence");
   property p_gpio_busy;
      $changed(GPIO_OUT) && bad_reg == 3'h0 |-> $past(SEQ_BUSY);
   endproperty
   a_gpio_busy: assert property (p_gpio_busy)
      else $error("GPIO changed outside a sequence");
   property p_pitch;
      $changed(REG_ENABLE) && bad_reg == 3'h0 |-> gap_reg >= PITCH_GAP;
   endproperty
   a_pitch: assert property (p_pitch)
      else $error("Slots closer than the pitch");
   property p_eight;
      $rose(SEQ_BUSY) |-> SEQ_BUSY [*8];
   endproperty
   a_eight: assert property (p_eight)
      else $error("Sequence ended too early");
   property p_batt_gate;
      !BATTERY_OK_INDICATION |-> ##1 !$rose(SEQ_BUSY);
   endproperty
   a_batt_gate: assert property (p_batt_gate)
      else $error("Sequence started on a weak battery");
   property p_mono;
      $changed(REG_ENABLE) && bad_reg == 3'h0 |->
         (REG_ENABLE & $past(REG_ENABLE)) == $past(REG_ENABLE) ||
         (REG_ENABLE & ~$past(REG_ENABLE)) == 8'h00;
   endproperty
   a_mono: assert property (p_mono)
      else $error("Slot switched both ways at once");
endmodule
`default_nettype wire

// [verification/oss_ap_model.sv]
`default_nettype none
module oss_ap_model (
   // Clock
   input wire logic       CLOCK,
   // Resources ready, sleep control, adapter, loss, alarm two/one, on-key
   output var logic [6:0] EVENTS
);
   timeunit 1ns;
   timeprecision 1ps;
   initial EVENTS = 7'h60;
   task automatic pulse(input int i);
      @(posedge CLOCK);
      EVENTS[i] <= 1'b1;
      repeat (2) @(posedge CLOCK);
      EVENTS[i] <= 1'b0;
   endtask
   // Processor steers sleep through the control input
   task automatic sleep_ctl(input logic v);
      @(posedge CLOCK);
      EVENTS[5] <= v;
   endtask
endmodule
`default_nettype wire

// [verification/tb_oss_sequencer.sv]
`default_nettype none
module tb_oss_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLOCK = 1'b0, RST_N = 1'b0, AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0, AVS_WAITREQUEST, SEQ_BUSY;
   logic [7:0]  AVS_ADDRESS = 8'h00, REG_ENABLE;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
   logic [3:0]  AVS_BYTEENABLE = 4'hf, GPIO_OUT;
   logic        BATTERY_OK_INDICATION = 1'b1, BATTERY_OVERVOLTAGE = 1'b0;
   logic        SLOW_OSCILLATOR_OK = 1'b1, SLEEP_INPUT_POLARITY_FUSE = 1'b1;
   logic        HARDWARE_RESET_INPUT = 1'b0, MANUAL_RESET_AUTOWAKE = 1'b0;
   logic        WATCHDOG_AUTOWAKE = 1'b0;
   logic [4:0]  flt = 5'h00;
   logic [6:0]  events;
   wire         ONKEY_INPUT, ALARM_ONE_EVENT, ALARM_TWO_EVENT;
   wire         MOMENTARY_POWER_LOSS_EVENT, ADAPTER_PRESENT_INPUT;
   wire         SLEEP_CONTROL_INPUT, RESOURCES_READY, BATTERY_RESET_LEVEL;
   wire         OVER_TEMPERATURE, EXTERNAL_SHUTDOWN_INPUT, MANUAL_RESET;
   wire         WATCHDOG_EXPIRED;
   int          num_errors = 0, checks_done = 0;
   assign {RESOURCES_READY, SLEEP_CONTROL_INPUT, ADAPTER_PRESENT_INPUT,
           MOMENTARY_POWER_LOSS_EVENT, ALARM_TWO_EVENT, ALARM_ONE_EVENT,
           ONKEY_INPUT} = events;
   assign {WATCHDOG_EXPIRED, MANUAL_RESET, EXTERNAL_SHUTDOWN_INPUT,
           OVER_TEMPERATURE} = flt[4:1];
   assign BATTERY_RESET_LEVEL = !flt[0];
   oss_sequencer #(.PITCH_BASE_NS(200), .READY_TMO_CYCLES(200)) i_dut (.*);
   oss_ap_model i_ap (.CLOCK(CLOCK), .EVENTS(events));
   always #20 CLOCK = ~CLOCK;
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge CLOCK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
      q = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic run_seq;
      while (SEQ_BUSY !== 1'b1) @(posedge CLOCK);
      while (SEQ_BUSY !== 1'b0) @(posedge CLOCK);
   endtask
   task automatic end_sim;
      $display("Checks: %0d, mismatches: %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      end_sim;
   end
   initial begin
      repeat (5) @(posedge CLOCK);
      RST_N <= 1'b1;
      rdc(8'h04, 32'h1);
      rdc(8'h0c, 32'h76543210);
      rdc(8'h10, 32'hfedc);
      rdc(8'h14, 32'h1);
      acc(1'b1, 8'h00, 32'h1);
      repeat (6) @(posedge CLOCK);
      rdc(8'h14, 32'h2);
      i_ap.pulse(0);
      run_seq;
      chk({24'h0, REG_ENABLE}, 32'hff);
      chk({28'h0, GPIO_OUT}, 32'hf);
      rdc(8'h14, 32'h3f08);
      acc(1'b1, 8'h00, 32'h20);
      i_ap.sleep_ctl(1'b0);
      run_seq;
      chk({28'h0, GPIO_OUT}, 32'h0);
      chk({24'h0, REG_ENABLE}, 32'hff);
      rdc(8'h14, 32'h2010);
      i_ap.sleep_ctl(1'b1);
      run_seq;
      chk({28'h0, GPIO_OUT}, 32'hf);
      rdc(8'h14, 32'h2f08);
      acc(1'b1, 8'h04, 32'h3e);
      BATTERY_OK_INDICATION <= 1'b0;
      BATTERY_OVERVOLTAGE <= 1'b1;
      SLOW_OSCILLATOR_OK <= 1'b0;
      repeat (2) @(posedge CLOCK);
      BATTERY_OK_INDICATION <= 1'b1;
      BATTERY_OVERVOLTAGE <= 1'b0;
      SLOW_OSCILLATOR_OK <= 1'b1;
      repeat (3) @(posedge CLOCK);
      chk({24'h0, REG_ENABLE}, 32'h0);
      rdc(8'h04, 32'h1);
      rdc(8'h14, 32'h2f01);
      for (int i = 0; i < 5; i++) begin
         acc(1'b1, 8'h04, 32'h0);
         i_ap.pulse(i);
         repeat (8) @(posedge CLOCK);
         rdc(8'h14, i ? 32'h3001 : 32'h2f01);
         acc(1'b1, 8'h04, 32'h1 << i);
         i_ap.pulse(i);
         run_seq;
         chk({24'h0, REG_ENABLE}, 32'hff);
         flt[i] <= 1'b1;
         repeat (2) @(posedge CLOCK);
         flt[i] <= 1'b0;
         run_seq;
         chk({24'h0, REG_ENABLE}, 32'h0);
         chk({28'h0, GPIO_OUT}, 32'h0);
         rdc(8'h04, 32'h1);
      end
      i_ap.pulse(0);
      run_seq;
      HARDWARE_RESET_INPUT <= 1'b1;
      repeat (2) @(posedge CLOCK);
      HARDWARE_RESET_INPUT <= 1'b0;
      run_seq;
      run_seq;
      chk({24'h0, REG_ENABLE}, 32'hff);
      rdc(8'h18, 32'h0);
      end_sim;
   end
endmodule
bind oss_sequencer oss_seq_props #(.PITCH_BASE_NS(PITCH_BASE_NS)) i_props (
   .CLOCK, .RST_N, .BATTERY_OK_INDICATION, .BATTERY_OVERVOLTAGE,
   .SLOW_OSCILLATOR_OK, .REG_ENABLE, .GPIO_OUT, .SEQ_BUSY);
`default_nettype wire
